// >>> atc_pkg.sv
// Package holding constants and types of the converter trigger control block.
`default_nettype none

package atc_pkg;

	// ----------------------------------------------------------------
	// Control bit positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned BIT_IRQ_ENABLE   = 14;
	localparam int unsigned BIT_RSVD_13      = 13;
	localparam int unsigned BIT_RSVD_12      = 12;
	localparam int unsigned BIT_TRIG_ENABLE  = 11;
	localparam int unsigned BIT_RSVD_10      = 10;
	localparam int unsigned BIT_FLAG_COMBINE = 9;
	localparam int unsigned SEL_MSB          = 3;
	localparam int unsigned SEL_LSB          = 0;
	localparam logic [15:0] CTRL_RESET       = 16'h0000;
	localparam logic [15:0] CTRL_RSVD_MASK   = 16'h3400;

	// ----------------------------------------------------------------
	// Group 0 trigger select encodings
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_EXT_PIN   = 4'h0;
	localparam logic [3:0] SEL_CHAN_A    = 4'h1;
	localparam logic [3:0] SEL_CHAN0_CMP = 4'h2;
	localparam logic [3:0] SEL_DELAY_A   = 4'h3;
	localparam logic [3:0] SEL_DELAY_B   = 4'h4;

	// ----------------------------------------------------------------
	// Scan modes and states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_SCAN4  = 2'h1,
		MODE_SCAN2  = 2'h2
	} atc_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CONV = 3'h2,
		ST_WAIT = 3'h4
	} atc_state_t;

	// Timer trigger bundle, one pulse per event.
	typedef struct packed {
		logic chan_a_compare_or_trough_trigger;
		logic chan0_compare_trigger;
		logic delayed_start_request_a;
		logic delayed_start_request_b;
	} atc_timer_trig_t;

endpackage : atc_pkg

`default_nettype wire

// >>> atc_pin_sync.sv
// Three-stage synchroniser with agreement filter for an outside pin.
`default_nettype none

module atc_pin_sync (
	input  wire logic i_core_clk,
	input  wire logic i_reset_n,
	input  wire logic i_pin,
	output logic      o_level
);

	logic [2:0] sync_reg;
	logic [2:0] sync_next;
	logic       level_reg;
	logic       level_next;

	// Stage one feeds stage two only; the filter reads stages two and three.
	always_comb begin
		sync_next  = {sync_reg[1:0], i_pin};
		level_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : level_reg;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_reg  <= 3'h0;
			level_reg <= 1'b0;
		end else begin
			sync_reg  <= sync_next;
			level_reg <= level_next;
		end
	end

	assign o_level = level_reg;

endmodule : atc_pin_sync

`default_nettype wire

// >>> atc_trigger_control.sv
// Trigger selection, start and end-flag control of the A/D converter.
`default_nettype none
//
// Behaviour
// - End interrupt request leaves only while the interrupt enable bit is one.
// - Reserved bits 13, 12, 10 read zero; software writes them zero.
// - Trigger enable zero blocks pin and timer starts; one accepts both.
// - Flag combine acts only with triggers enabled in 2-channel scan.
// - Combine zero: end flag sets when either group conversion completes.
// - Combine one: end flag sets after both groups complete, any order.
// - Four-bit select picks group 0 start source in all three modes.
// - Codes 0..4 pick pin, chan A, chan 0, delayed A, delayed B.

module atc_trigger_control (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_reset_n,
	input  wire logic                    i_ctrl_wr,
	input  wire logic [15:0]             i_ctrl_wdata,
	output logic      [15:0]             o_ctrl_rdata,
	input  wire logic                    i_sw_start,
	input  wire logic                    i_sw_stop,
	input  wire logic [1:0]              i_scan_mode,
	input  wire logic                    i_external_trigger_pin,
	input  wire atc_pkg::atc_timer_trig_t i_timer_trig,
	input  wire logic                    i_group1_trigger,
	input  wire logic                    i_conv_done,
	input  wire logic                    i_flag_clear,
	output logic                         o_conv_start_bit,
	output logic                         o_group0_start,
	output logic                         o_group1_start,
	output logic                         o_conv_end_flag,
	output logic                         o_conv_end_irq
);

	// ----------------------------------------------------------------
	// Pin synchroniser and edge detection
	// ----------------------------------------------------------------
	logic pin_level;
	logic pin_prev_reg;
	logic pin_prev_next;
	logic pin_fall;

	atc_pin_sync u_pin_sync (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.i_pin      (i_external_trigger_pin),
		.o_level    (pin_level)
	);

	// The external pin is active low, so a start is its falling edge.
	always_comb begin
		pin_prev_next = pin_level;
		pin_fall      = pin_prev_reg & ~pin_level;
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;

	// Reserved bits are masked on write so that they always read zero.
	always_comb begin
		ctrl_next = ctrl_reg;
		if (i_ctrl_wr) begin
			ctrl_next = i_ctrl_wdata & ~atc_pkg::CTRL_RSVD_MASK;
		end
	end

	logic       irq_en;
	logic       trig_en;
	logic       combine;
	logic [3:0] g0_sel;
	logic       scan2;

	assign irq_en  = ctrl_reg[atc_pkg::BIT_IRQ_ENABLE];
	assign trig_en = ctrl_reg[atc_pkg::BIT_TRIG_ENABLE];
	assign combine = ctrl_reg[atc_pkg::BIT_FLAG_COMBINE];
	assign g0_sel  = ctrl_reg[atc_pkg::SEL_MSB:atc_pkg::SEL_LSB];
	assign scan2   = (i_scan_mode == atc_pkg::MODE_SCAN2);

	// ----------------------------------------------------------------
	// Trigger source selection
	// ----------------------------------------------------------------
	// Prohibited select codes give no source at all rather than aliasing.
	function automatic logic pick_source(input logic [3:0] sel, input logic pin,
		input atc_pkg::atc_timer_trig_t t);
		logic r;
		r = 1'b0;
		unique case (sel)
			atc_pkg::SEL_EXT_PIN:   r = pin;
			atc_pkg::SEL_CHAN_A:    r = t.chan_a_compare_or_trough_trigger;
			atc_pkg::SEL_CHAN0_CMP: r = t.chan0_compare_trigger;
			atc_pkg::SEL_DELAY_A:   r = t.delayed_start_request_a;
			atc_pkg::SEL_DELAY_B:   r = t.delayed_start_request_b;
			default:                r = 1'b0;
		endcase
		return r;
	endfunction : pick_source

	logic g0_event;
	logic g1_event;

	always_comb begin
		g0_event = trig_en & pick_source(g0_sel, pin_fall, i_timer_trig);
		g1_event = trig_en & scan2 & i_group1_trigger;
	end

	// ----------------------------------------------------------------
	// Conversion sequence and end flag
	// ----------------------------------------------------------------
	atc_pkg::atc_state_t state_reg;
	atc_pkg::atc_state_t state_next;
	logic start_reg;
	logic start_next;
	logic g0_start_reg;
	logic g0_start_next;
	logic g1_start_reg;
	logic g1_start_next;
	logic cur_g1_reg;
	logic cur_g1_next;
	logic g0_done_reg;
	logic g0_done_next;
	logic g1_done_reg;
	logic g1_done_next;
	logic flag_reg;
	logic flag_next;
	logic irq_reg;
	logic irq_next;
	logic set_flag;
	logic both_mode;

	// Group 1 events arriving while busy are dropped; software must keep
	// group triggers apart, which keeps this engine single-issue.
	always_comb begin
		state_next    = state_reg;
		start_next    = start_reg;
		g0_start_next = 1'b0;
		g1_start_next = 1'b0;
		cur_g1_next   = cur_g1_reg;
		g0_done_next  = g0_done_reg;
		g1_done_next  = g1_done_reg;
		set_flag      = 1'b0;
		both_mode     = trig_en & scan2 & combine;
		unique case (state_reg)
			atc_pkg::ST_IDLE: begin
				if (g0_event || i_sw_start) begin
					state_next    = atc_pkg::ST_CONV;
					start_next    = 1'b1;
					g0_start_next = 1'b1;
					cur_g1_next   = 1'b0;
				end else if (g1_event) begin
					state_next    = atc_pkg::ST_CONV;
					start_next    = 1'b1;
					g1_start_next = 1'b1;
					cur_g1_next   = 1'b1;
				end
			end
			atc_pkg::ST_CONV: begin
				if (i_conv_done) begin
					state_next = atc_pkg::ST_IDLE;
					start_next = 1'b0;
					if (!both_mode) begin
						set_flag = 1'b1;
					end else if (cur_g1_reg) begin
						g1_done_next = 1'b1;
					end else begin
						g0_done_next = 1'b1;
					end
				end
			end
			default: begin
				state_next = atc_pkg::ST_IDLE;
			end
		endcase
		if (both_mode && g0_done_next && g1_done_next) begin
			set_flag     = 1'b1;
			g0_done_next = 1'b0;
			g1_done_next = 1'b0;
		end
		if (!both_mode) begin
			g0_done_next = 1'b0;
			g1_done_next = 1'b0;
		end
		if (i_sw_stop) begin
			state_next    = atc_pkg::ST_IDLE;
			start_next    = 1'b0;
			g0_start_next = 1'b0;
			g1_start_next = 1'b0;
		end
		// A set in the same cycle as a clear wins.
		flag_next = set_flag | (flag_reg & ~i_flag_clear);
		irq_next  = flag_next & irq_en;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_reg     <= atc_pkg::CTRL_RESET;
			pin_prev_reg <= 1'b0;
			state_reg    <= atc_pkg::ST_IDLE;
			start_reg    <= 1'b0;
			g0_start_reg <= 1'b0;
			g1_start_reg <= 1'b0;
			cur_g1_reg   <= 1'b0;
			g0_done_reg  <= 1'b0;
			g1_done_reg  <= 1'b0;
			flag_reg     <= 1'b0;
			irq_reg      <= 1'b0;
		end else begin
			ctrl_reg     <= ctrl_next;
			pin_prev_reg <= pin_prev_next;
			state_reg    <= state_next;
			start_reg    <= start_next;
			g0_start_reg <= g0_start_next;
			g1_start_reg <= g1_start_next;
			cur_g1_reg   <= cur_g1_next;
			g0_done_reg  <= g0_done_next;
			g1_done_reg  <= g1_done_next;
			flag_reg     <= flag_next;
			irq_reg      <= irq_next;
		end
	end

	assign o_ctrl_rdata     = ctrl_reg;
	assign o_conv_start_bit = start_reg;
	assign o_group0_start   = g0_start_reg;
	assign o_group1_start   = g1_start_reg;
	assign o_conv_end_flag  = flag_reg;
	assign o_conv_end_irq   = irq_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_irq_gated;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		o_conv_end_irq |-> (o_conv_end_flag && $past(irq_en));
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("irq raised while disabled");

	property p_rsvd_zero;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(o_ctrl_rdata[13:12] == 2'h0) && !o_ctrl_rdata[10];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads nonzero");

	property p_no_trig_when_off;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(!trig_en && !i_sw_start && state_reg == atc_pkg::ST_IDLE) |=> !o_group0_start && !o_group1_start;
	endproperty
	a_no_trig_when_off: assert property (p_no_trig_when_off) else $error("start without trigger enable");

	property p_pin_start;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(trig_en && g0_sel == atc_pkg::SEL_EXT_PIN && pin_fall && state_reg == atc_pkg::ST_IDLE && !i_sw_stop)
			|=> o_group0_start && o_conv_start_bit;
	endproperty
	a_pin_start: assert property (p_pin_start) else $error("pin trigger did not start");

	property p_bad_sel;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(g0_sel > atc_pkg::SEL_DELAY_B && !i_sw_start && state_reg == atc_pkg::ST_IDLE) |=> !o_group0_start;
	endproperty
	a_bad_sel: assert property (p_bad_sel) else $error("prohibited select started group 0");

	property p_flag_either;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(state_reg == atc_pkg::ST_CONV && i_conv_done && !both_mode) |=> o_conv_end_flag;
	endproperty
	a_flag_either: assert property (p_flag_either) else $error("flag missed on single completion");

	property p_flag_both;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		(both_mode && $rose(o_conv_end_flag)) |-> $past(g0_done_reg || g1_done_reg);
	endproperty
	a_flag_both: assert property (p_flag_both) else $error("combined flag set too early");

	property p_combine_ignored;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		!scan2 |=> !g0_done_reg && !g1_done_reg;
	endproperty
	a_combine_ignored: assert property (p_combine_ignored) else $error("combine active outside scan2");

	property p_start_seq;
		@(posedge i_core_clk) disable iff (!i_reset_n)
		o_group0_start |-> o_conv_start_bit;
	endproperty
	a_start_seq: assert property (p_start_seq) else $error("group 0 start without start bit");

endmodule : atc_trigger_control

`default_nettype wire

// >>> atc_timer_model.sv
// Behavioural model of the timer unit and the external trigger pin.
`default_nettype none

module atc_timer_model (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_fire,
	input  wire logic [2:0]              i_src,
	output var  atc_pkg::atc_timer_trig_t o_timer_trig,
	output var  logic                    o_pin_n,
	output var  logic                    o_group1_trigger
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       fire_q;
	logic [2:0] src_q;
	int         low_cnt;

	// ----------------------------------------------------------------
	// Event generation
	// ----------------------------------------------------------------
	// Code 0 pulls the pin low for eight cycles, 1 to 4 pulse one timer line, 5 pulses group 1.
	// One process owns every output, so each line has a single driver.
	// The request is sampled on the edge so it never races the bench; one source per cycle only.
	initial begin
		o_timer_trig = '0;
		o_pin_n = 1'b1;
		o_group1_trigger = 1'b0;
		low_cnt = 0;
		forever begin
			@(posedge i_core_clk);
			fire_q = i_fire;
			src_q = i_src;
			#1;
			o_timer_trig = '0;
			o_group1_trigger = 1'b0;
			if (low_cnt > 0) begin
				low_cnt--;
			end
			o_pin_n = (low_cnt == 0);
			if (fire_q) begin
				if (src_q == 3'h0) begin
					low_cnt = 8;
					o_pin_n = 1'b0;
				end else if (src_q == 3'h5) begin
					o_group1_trigger = 1'b1;
				end else begin
					o_timer_trig = atc_pkg::atc_timer_trig_t'(4'h1 << (3'h4 - src_q));
				end
			end
		end
	end

endmodule : atc_timer_model

`default_nettype wire

// >>> adc_trigger_control_tb_top.sv
// Self-checking testbench of the converter trigger control block.
`default_nettype none

module adc_trigger_control_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic                     clk = 1'b0;
	logic                     rst_n = 1'b0;
	logic                     wr = 1'b0;
	logic [15:0]              wdata = 16'h0000;
	logic [15:0]              rdata;
	logic                     sw_start = 1'b0;
	logic                     sw_stop = 1'b0;
	logic [1:0]               mode = 2'h0;
	logic                     pin_n;
	atc_pkg::atc_timer_trig_t ttrig;
	logic                     g1_trig;
	logic                     done = 1'b0;
	logic                     fclr = 1'b0;
	logic                     sbit, g0s, g1s, flag, irq;
	logic                     fire = 1'b0;
	logic [2:0]               src = 3'h0;
	int                       err_count = 0;
	int                       compares = 0;

	always #2.5 clk = ~clk;

	atc_timer_model u_tmr (.i_core_clk(clk), .i_fire(fire), .i_src(src), .o_timer_trig(ttrig),
		.o_pin_n(pin_n), .o_group1_trigger(g1_trig));

	atc_trigger_control uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_ctrl_wr(wr), .i_ctrl_wdata(wdata),
		.o_ctrl_rdata(rdata), .i_sw_start(sw_start), .i_sw_stop(sw_stop), .i_scan_mode(mode),
		.i_external_trigger_pin(pin_n), .i_timer_trig(ttrig), .i_group1_trigger(g1_trig),
		.i_conv_done(done), .i_flag_clear(fclr), .o_conv_start_bit(sbit), .o_group0_start(g0s),
		.o_group1_start(g1s), .o_conv_end_flag(flag), .o_conv_end_irq(irq));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	// Inputs move one nanosecond after the edge, so the design never sees them change on it.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// The start bit is always cleared first, because control changes are unsafe mid-conversion.
	task automatic wr_ctrl(input logic [15:0] d);
		sw_stop = 1'b1;
		cyc(1);
		sw_stop = 1'b0;
		wr = 1'b1;
		wdata = d;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask : wr_ctrl

	// Fires one source, watches for a start and completes any conversion it began.
	task automatic run(input logic [2:0] s, input logic g0, input logic g1, input logic [1:0] fi);
		logic seen;
		seen = 1'b0;
		fire = 1'b1;
		src = s;
		cyc(1);
		fire = 1'b0;
		for (int i = 0; i < 12 && !seen; i++) begin
			cyc(1);
			seen = g0s | g1s;
		end
		chk({g0s, g1s}, {g0, g1});
		if (seen) begin
			chk(sbit, 1'b1);
			done = 1'b1;
			cyc(1);
			done = 1'b0;
			chk({flag, irq}, fi);
		end
	endtask : run

	task automatic clr();
		fclr = 1'b1;
		cyc(1);
		fclr = 1'b0;
		cyc(1);
	endtask : clr

	task automatic finish_test();
		if (err_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	// Each source is tried with the wrong source first; for code 4, code^1 sends group 1 in single mode.
	initial begin
		cyc(20);
		rst_n = 1'b1;
		cyc(5);
		chk(rdata, 16'h0000);
		chk({sbit, flag, irq}, 3'h0);
		wr_ctrl(16'hffff);
		chk(rdata, 16'hcbff);
		wr_ctrl(16'h0001);
		run(3'h1, 1'b0, 1'b0, 2'h0);
		// A software start needs no trigger enable, and a stop aborts it without an end flag.
		sw_start = 1'b1;
		cyc(1);
		sw_start = 1'b0;
		chk({g0s, g1s, sbit}, 3'h5);
		sw_stop = 1'b1;
		cyc(1);
		sw_stop = 1'b0;
		chk({sbit, flag}, 2'h0);
		cyc(1);
		for (int k = 0; k < 5; k++) begin
			wr_ctrl(16'h0800 | 16'(k));
			run(3'(k ^ 1), 1'b0, 1'b0, 2'h0);
			run(3'(k), 1'b1, 1'b0, 2'h2);
			clr();
		end
		wr_ctrl(16'h0805);
		for (int k = 0; k < 5; k++) begin
			run(3'(k), 1'b0, 1'b0, 2'h0);
		end
		wr_ctrl(16'h4801);
		run(3'h1, 1'b1, 1'b0, 2'h3);
		clr();
		chk(irq, 1'b0);
		mode = 2'h2;
		wr_ctrl(16'h0a01);
		run(3'h1, 1'b1, 1'b0, 2'h0);
		run(3'h5, 1'b0, 1'b1, 2'h2);
		clr();
		run(3'h5, 1'b0, 1'b1, 2'h0);
		run(3'h1, 1'b1, 1'b0, 2'h2);
		clr();
		wr_ctrl(16'h0801);
		run(3'h5, 1'b0, 1'b1, 2'h2);
		clr();
		mode = 2'h0;
		wr_ctrl(16'h0a01);
		run(3'h1, 1'b1, 1'b0, 2'h2);
		clr();
		// Four-channel scan ignores both the combine bit and the group 1 trigger.
		mode = 2'h1;
		run(3'h5, 1'b0, 1'b0, 2'h0);
		run(3'h1, 1'b1, 1'b0, 2'h2);
		finish_test();
	end

	// A hang is cut short well past the few hundred cycles the tests need.
	initial begin
		#50000;
		err_count++;
		finish_test();
	end

endmodule : adc_trigger_control_tb_top

`default_nettype wire
